/* bench/low_power_mode_sequencer_test.sv */
// Self-checking bench for the low-power mode sequencer
`timescale 1ns/1ns
module low_power_mode_sequencer_test;
    import lpm_pkg::*;
    localparam int PLL_SIM = 20;
    localparam int OSC_SIM = 10;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, sleep_exec;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        wake_gpio_pin, wake_start, wake_busy, err, irq;
    logic [15:0] wake_hold;
    logic        system_clock_out_en, core_clock_input_en, peripheral_clock_en, pll_en;
    logic        oscillator_en, internal_oscillator_one_en, internal_oscillator_two_en;
    logic        watchdog_en, external_clock_output, program_resume, wake_interrupt;
    int          failures, check_count, t_pin, t_osc, t_core, t_res;

    low_power_mode_sequencer #(.PLL_LOCK_CYCLES(PLL_SIM), .OSC_START_CYCLES(OSC_SIM)) uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sleep_exec(sleep_exec), .wake_gpio_pin(wake_gpio_pin),
        .system_clock_out_en(system_clock_out_en), .core_clock_input_en(core_clock_input_en),
        .peripheral_clock_en(peripheral_clock_en), .pll_en(pll_en),
        .oscillator_en(oscillator_en),
        .internal_oscillator_one_en(internal_oscillator_one_en),
        .internal_oscillator_two_en(internal_oscillator_two_en), .watchdog_en(watchdog_en),
        .external_clock_output(external_clock_output), .program_resume(program_resume),
        .wake_interrupt(wake_interrupt));
    wake_source wake_model (.pclk(pclk), .presetn(presetn), .start(wake_start),
        .hold_cycles(wake_hold), .wake_gpio_pin(wake_gpio_pin), .busy(wake_busy));

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    task automatic chk(input bit ok, input string msg);
        check_count++;
        if (!ok) begin
            failures++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask : chk

    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : test_done

    // Request stands until pready is sampled high at a rising edge; data is taken there
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (n >= 16) begin
            chk(1'b0, "bus timeout");
            test_done;
        end
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic sleep_go(input int flush);
        int k, fall, last_hi;
        fall    = 0;
        last_hi = 0;
        @(posedge pclk);
        sleep_exec <= 1'b1;
        @(posedge pclk);
        sleep_exec <= 1'b0;
        for (k = 1; k <= 70; k++) begin
            @(posedge pclk);
            #1;
            if (system_clock_out_en === 1'b0 && fall == 0) fall = k;
            if (external_clock_output === 1'b1) last_hi = k;
        end
        chk(fall == flush, "flush length");
        chk(last_hi >= 30 && last_hi < 45, "clock out stop");
    endtask : sleep_go

    task automatic watch(input int lim);
        int k;
        t_pin  = -1;
        t_osc  = -1;
        t_core = -1;
        t_res  = -1;
        @(posedge pclk);
        wake_start <= 1'b1;
        @(posedge pclk);
        wake_start <= 1'b0;
        for (k = 0; k < lim && t_res < 0; k++) begin
            @(posedge pclk);
            #1;
            if (wake_gpio_pin === 1'b0 && t_pin < 0) t_pin = k;
            if (oscillator_en === 1'b1 && t_osc < 0) t_osc = k;
            if (core_clock_input_en === 1'b1 && t_core < 0) t_core = k;
            if (program_resume === 1'b1) t_res = k;
            if (program_resume === 1'b1) irq = wake_interrupt;
        end
    endtask : watch

    task automatic reg_test;
        apb(1'b0, LPCFG_OFS, 32'h0);
        chk(rd === {24'h0, LPCFG_RST} && err === 1'b0, "config reset");
        apb(1'b0, KEEP_OFS, 32'h0);
        chk(rd === {23'h0, KEEP_RST}, "control reset");
        apb(1'b1, STATUS_OFS, 32'hffff_ffff);
        apb(1'b0, STATUS_OFS, 32'h0);
        chk(rd === {25'h0, ST_RUN}, "status read-only");
        apb(1'b1, 8'h0c, 32'hffff_ffff);
        chk(err === 1'b1, "unmapped write");
        apb(1'b0, 8'h0c, 32'h0);
        chk(err === 1'b1 && rd === 32'h0, "unmapped read");
        apb(1'b1, LPCFG_OFS, 32'h0000_00fd);
        apb(1'b0, LPCFG_OFS, 32'h0);
        chk(rd === 32'h0000_00fd, "config readback");
        $display("test registers done");
    endtask : reg_test

    task automatic standby_run(input logic [1:0] div, input logic [1:0] mem,
                               input logic ien, input int flush, input int limit);
        logic [31:0] keep;
        keep = {23'h0, ien, mem, 4'h0, div};
        apb(1'b1, LPCFG_OFS, 32'h0);
        apb(1'b1, KEEP_OFS, keep);
        apb(1'b0, KEEP_OFS, 32'h0);
        chk(rd === keep, "control readback");
        sleep_go(flush);
        chk(peripheral_clock_en === 1'b0 && pll_en === 1'b1 && watchdog_en === 1'b1,
            "standby clocks");
        apb(1'b0, STATUS_OFS, 32'h0);
        chk(rd[6:0] === ST_STANDBY, "standby state");
        wake_hold <= 16'd5;
        watch(1400);
        chk(t_res >= 0 && t_res - t_pin >= limit && t_res - t_pin <= limit + 9,
            "standby latency");
        chk(irq === ien, "wake interrupt");
        $display("test standby div %0d done", div);
    endtask : standby_run

    task automatic qual_run;
        apb(1'b1, LPCFG_OFS, 32'h0000_0016);
        apb(1'b1, KEEP_OFS, 32'h0000_0080);
        sleep_go(16);
        wake_hold <= 16'd5;
        watch(300);
        chk(t_res < 0, "short pulse ignored");
        wake_hold <= 16'd9;
        watch(400);
        chk(t_res >= 0 && t_res - t_pin >= 100 && t_res - t_pin <= 113,
            "qualified latency");
        $display("test qualified wake done");
    endtask : qual_run

    // Low control bits: divider, keep one, keep two, keep watchdog, crystal source
    task automatic halt_run(input logic [1:0] mem, input logic [5:0] low, input int flush,
                            input int limit);
        apb(1'b1, LPCFG_OFS, 32'h0000_0001);
        apb(1'b1, KEEP_OFS, {23'h0, 1'b1, mem, low});
        sleep_go(flush);
        chk(oscillator_en === 1'b0 && core_clock_input_en === 1'b0 && pll_en === 1'b0,
            "halt stops oscillator");
        chk(peripheral_clock_en === 1'b0, "halt stops peripherals");
        chk(internal_oscillator_one_en === (low[2] | !low[5]) &&
            internal_oscillator_two_en === (low[3] | !low[5]) &&
            watchdog_en === low[4], "keep-alive");
        apb(1'b0, STATUS_OFS, 32'h0);
        chk(rd[6:0] === ST_HALT, "halt state");
        wake_hold <= 16'(OSC_SIM + 6);
        watch(1400);
        chk(t_osc >= t_pin && t_osc <= t_pin + 5, "oscillator restart");
        chk(t_core - t_osc >= OSC_SIM + PLL_SIM - 1 &&
            t_core - t_osc <= OSC_SIM + PLL_SIM + 2, "lock wait");
        chk(t_res >= 0 && t_res - t_core >= limit - 2 && t_res - t_core <= limit + 1,
            "halt latency");
        chk(irq === 1'b1, "enabled interrupt");
        $display("test halt mem %0d done", mem);
    endtask : halt_run

    initial begin
        presetn     = 1'b0;
        psel        = 1'b0;
        penable     = 1'b0;
        pwrite      = 1'b0;
        paddr       = 8'h00;
        pwdata      = 32'h0;
        sleep_exec  = 1'b0;
        wake_start  = 1'b0;
        wake_hold   = 16'h0000;
        failures    = 0;
        check_count = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        reg_test;
        standby_run(2'd0, 2'd2, 1'b1, 16, 100);
        standby_run(2'd1, 2'd0, 1'b0, 16, 100);
        standby_run(2'd2, 2'd1, 1'b1, 32, 1125);
        standby_run(2'd3, 2'd3, 1'b0, 64, 100);
        qual_run;
        halt_run(2'd1, 6'h25, 16, 1125);
        halt_run(2'd2, 6'h1a, 32, 35);
        test_done;
    end
endmodule : low_power_mode_sequencer_test

/* bench/wake_source.sv */
// Wake source model driving the wake pin of the sequencer
`timescale 1ns/1ns
module wake_source (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        start,
    input  wire logic [15:0] hold_cycles,
    output logic             wake_gpio_pin,
    output logic             busy
);
    logic [15:0] cnt_ff;
    logic [2:0]  gap_ff;

    // Pin has a pull-up, so a released pin reads high; one fall and one rise, no glitch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_gpio_pin <= 1'b1;
            busy          <= 1'b0;
            cnt_ff        <= 16'h0000;
            gap_ff        <= 3'h0;
        end else if (start && !busy) begin
            busy   <= 1'b1;
            gap_ff <= 3'h4;
        end else if (busy && gap_ff != 3'h0) begin
            gap_ff <= gap_ff - 3'h1;
            if (gap_ff == 3'h1) begin
                wake_gpio_pin <= 1'b0;
                cnt_ff        <= hold_cycles;
            end
        end else if (busy) begin
            cnt_ff <= cnt_ff - 16'h0001;
            if (cnt_ff == 16'h0001) begin
                wake_gpio_pin <= 1'b1;
                busy          <= 1'b0;
            end
        end
    end
endmodule : wake_source

/* pkg/lpm_pkg.sv */
// Constants, register map and state codes for the low-power mode sequencer
// How it works
// - Standby keeps system clock for 16, 32 or 64 cycles by divider select.
// - In standby peripheral clocks stop; PLL and watchdog keep running.
// - External clock output goes low 32 to 45 cycles after sleep.
// - Standby wake resumes within 100 cycles, or 1125 from sleeping flash.
// - Latency ends at the instruction after sleep; interrupt entry may take longer.
// - Halt keeps the same flush delay, then stops oscillator and core clock.
// - Halt stops peripherals and PLL; crystal source also stops internal oscillator.
// - Software keep-alive bits hold both internal oscillators and watchdog in halt.
// - Falling edge on wake pin restarts oscillator and begins leaving halt.
// - After oscillator start, wait PLL lock up to 1 ms before core clock.
// - After PLL lock resume within 1125 cycles from flash, 35 from RAM.
// - Wake interrupt is serviced after resume only when enabled.
package lpm_pkg;
    localparam int CLK_PERIOD_NS = 100;
    localparam int PLL_LOCK_MS   = 1;
    localparam int PLL_LOCK_CYC  = PLL_LOCK_MS * 1000000 / CLK_PERIOD_NS;
    localparam int OSC_START_US  = 100;
    localparam int OSC_START_CYC = OSC_START_US * 1000 / CLK_PERIOD_NS;
    localparam int CNT_W         = 14;

    localparam logic [6:0] FLUSH_CYC_SHORT = 7'd16;
    localparam logic [6:0] FLUSH_CYC_MID   = 7'd32;
    localparam logic [6:0] FLUSH_CYC_LONG  = 7'd64;
    localparam logic [6:0] XCLK_LOW_MIN    = 7'd32;
    localparam logic [6:0] ENTRY_CNT_MAX   = 7'd127;
    localparam logic [6:0] WAKE_PLAIN_CYC  = 7'd3;
    localparam logic [6:0] WAKE_QUAL_BASE  = 7'd2;
    localparam logic [CNT_W-1:0] RESUME_FAST_CYC = 14'd100;
    localparam logic [CNT_W-1:0] RESUME_SLOW_CYC = 14'd1125;
    localparam logic [CNT_W-1:0] RESUME_RAM_CYC  = 14'd35;

    localparam logic [7:0] LPCFG_OFS  = 8'h00;
    localparam logic [7:0] KEEP_OFS   = 8'h04;
    localparam logic [7:0] STATUS_OFS = 8'h08;

    localparam int CFG_HALT_BIT  = 0;
    localparam int CFG_QEN_BIT   = 1;
    localparam int CFG_QCNT_LSB  = 2;
    localparam int KEEP_DIV_LSB  = 0;
    localparam int KEEP_OSC1_BIT = 2;
    localparam int KEEP_OSC2_BIT = 3;
    localparam int KEEP_WD_BIT   = 4;
    localparam int KEEP_XTAL_BIT = 5;
    localparam int KEEP_MEM_LSB  = 6;
    localparam int KEEP_IEN_BIT  = 8;
    localparam logic [7:0] LPCFG_RST = 8'h00;
    localparam logic [8:0] KEEP_RST  = 9'h000;

    localparam logic [1:0] MEM_FLASH_ACTIVE = 2'h0;
    localparam logic [1:0] MEM_FLASH_SLEEP  = 2'h1;

    typedef enum logic [6:0] {
        ST_RUN       = 7'h01,
        ST_FLUSH     = 7'h02,
        ST_STANDBY   = 7'h04,
        ST_HALT      = 7'h08,
        ST_OSC_START = 7'h10,
        ST_PLL_LOCK  = 7'h20,
        ST_RESUME    = 7'h40
    } lpm_state_e;
endpackage : lpm_pkg

/* verilog/low_power_mode_sequencer.sv */
// Standby and halt sequencer with APB register access
//
// The APB register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
module low_power_mode_sequencer
    import lpm_pkg::*;
#(
    parameter int PLL_LOCK_CYCLES  = PLL_LOCK_CYC,
    parameter int OSC_START_CYCLES = OSC_START_CYC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        sleep_exec,
    input  wire logic        wake_gpio_pin,
    output logic             system_clock_out_en,
    output logic             core_clock_input_en,
    output logic             peripheral_clock_en,
    output logic             pll_en,
    output logic             oscillator_en,
    output logic             internal_oscillator_one_en,
    output logic             internal_oscillator_two_en,
    output logic             watchdog_en,
    output logic             external_clock_output,
    output logic             program_resume,
    output logic             wake_interrupt
);
    if (PLL_LOCK_CYCLES < 1 || PLL_LOCK_CYCLES >= 2**CNT_W) begin : g_chk_pll
        $error("PLL_LOCK_CYCLES out of counter range");
    end
    if (OSC_START_CYCLES < 1 || OSC_START_CYCLES >= 2**CNT_W) begin : g_chk_osc
        $error("OSC_START_CYCLES out of counter range");
    end
    localparam logic [CNT_W-1:0] PLL_LAST = CNT_W'(PLL_LOCK_CYCLES - 1);
    localparam logic [CNT_W-1:0] OSC_LAST = CNT_W'(OSC_START_CYCLES - 1);

    // APB slave: one wait state so read data comes from a flop
    logic        pready_ff, nxt_pready;
    logic        pslverr_ff, nxt_pslverr;
    logic [31:0] prdata_ff, nxt_prdata;
    logic [7:0]  lpcfg_ff, nxt_lpcfg;
    logic [8:0]  keep_ff, nxt_keep;
    logic        bus_hit;

    // Sequencer state
    lpm_state_e       state_ff, nxt_state;
    logic [6:0]       ent_ff, nxt_ent;
    logic [6:0]       qcnt_ff, nxt_qcnt;
    logic [CNT_W-1:0] cnt_ff, nxt_cnt;
    logic [CNT_W-1:0] lim_ff, nxt_lim;
    logic             resume_ff, nxt_resume;
    logic             irq_ff, nxt_irq;
    logic [8:0]       clk_en_ff, nxt_clk_en;
    logic             wake_s1_ff, wake_s2_ff, wake_d_ff;

    logic             sleep_go, wake_fall, stby_wake;
    logic [6:0]       flush_cyc, wake_need;
    logic             keep_wd, keep_xtal;

    always_comb begin
        bus_hit     = (paddr == LPCFG_OFS) || (paddr == KEEP_OFS) || (paddr == STATUS_OFS);
        nxt_pready  = psel && penable && !pready_ff;
        nxt_pslverr = psel && penable && !pready_ff && !bus_hit;
        nxt_prdata  = 32'h0000_0000;
        if (psel && penable && !pready_ff) begin
            unique case (paddr)
                LPCFG_OFS:  nxt_prdata = {24'h00_0000, lpcfg_ff};
                KEEP_OFS:   nxt_prdata = {23'h00_0000, keep_ff};
                STATUS_OFS: nxt_prdata = {18'h0_0000, qcnt_ff, state_ff};
                default:    nxt_prdata = 32'h0000_0000;
            endcase
        end
        nxt_lpcfg = lpcfg_ff;
        nxt_keep  = keep_ff;
        if (psel && penable && pready_ff && pwrite) begin
            if (paddr == LPCFG_OFS) begin
                nxt_lpcfg = pwdata[7:0];
            end
            if (paddr == KEEP_OFS) begin
                nxt_keep = pwdata[8:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
            lpcfg_ff   <= LPCFG_RST;
            keep_ff    <= KEEP_RST;
        end else begin
            pready_ff  <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            prdata_ff  <= nxt_prdata;
            lpcfg_ff   <= nxt_lpcfg;
            keep_ff    <= nxt_keep;
        end
    end

    // Wake pin is asynchronous; only the second stage and its delayed copy (wake_d_ff) feed logic
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_s1_ff <= 1'b1;
            wake_s2_ff <= 1'b1;
            wake_d_ff  <= 1'b1;
        end else begin
            wake_s1_ff <= wake_gpio_pin;
            wake_s2_ff <= wake_s1_ff;
            wake_d_ff  <= wake_s2_ff;
        end
    end

    always_comb begin
        keep_wd   = keep_ff[KEEP_WD_BIT];
        keep_xtal = keep_ff[KEEP_XTAL_BIT];
        unique case (keep_ff[KEEP_DIV_LSB +: 2])
            2'h2:    flush_cyc = FLUSH_CYC_MID;
            2'h3:    flush_cyc = FLUSH_CYC_LONG;
            default: flush_cyc = FLUSH_CYC_SHORT;
        endcase
        // Qualified width counts from the pin's low level, sampled per clock
        wake_need = lpcfg_ff[CFG_QEN_BIT]
                  ? WAKE_QUAL_BASE + {1'b0, lpcfg_ff[CFG_QCNT_LSB +: 6]}
                  : WAKE_PLAIN_CYC;
        sleep_go  = (state_ff == ST_RUN) && sleep_exec;
        wake_fall = wake_d_ff && !wake_s2_ff;
        // Only reachable after the flush, so a wake pulse that ends within the 16 to 64 flush cycles is ignored
        stby_wake = (state_ff == ST_STANDBY) && !wake_s2_ff && (qcnt_ff >= wake_need - 7'd1);

        nxt_state  = state_ff;
        nxt_cnt    = cnt_ff;
        nxt_lim    = lim_ff;
        nxt_resume = 1'b0;
        nxt_irq    = 1'b0;
        nxt_qcnt   = (state_ff == ST_STANDBY && !wake_s2_ff && qcnt_ff != 7'h7f)
                   ? qcnt_ff + 7'd1 : 7'd0;
        if (sleep_go) begin
            nxt_ent = 7'd1;
        end else if (state_ff != ST_RUN && ent_ff != ENTRY_CNT_MAX) begin
            nxt_ent = ent_ff + 7'd1;
        end else if (state_ff == ST_RUN) begin
            nxt_ent = 7'd0;
        end else begin
            nxt_ent = ent_ff;
        end

        unique case (state_ff)
            ST_RUN: begin
                if (sleep_go) begin
                    nxt_state = ST_FLUSH;
                end
            end
            ST_FLUSH: begin
                // Counter reads 1 in the first cycle after sleep, so this holds the full delay
                if (ent_ff == flush_cyc) begin
                    nxt_state = lpcfg_ff[CFG_HALT_BIT] ? ST_HALT : ST_STANDBY;
                end
            end
            ST_STANDBY: begin
                if (stby_wake) begin
                    nxt_state = ST_RESUME;
                    nxt_cnt   = '0;
                    nxt_lim   = (keep_ff[KEEP_MEM_LSB +: 2] == MEM_FLASH_SLEEP)
                              ? RESUME_SLOW_CYC - 14'd1 : RESUME_FAST_CYC - 14'd1;
                end
            end
            ST_HALT: begin
                if (wake_fall) begin
                    nxt_state = ST_OSC_START;
                    nxt_cnt   = '0;
                end
            end
            ST_OSC_START: begin
                nxt_cnt = cnt_ff + 14'd1;
                if (cnt_ff == OSC_LAST) begin
                    nxt_state = ST_PLL_LOCK;
                    nxt_cnt   = '0;
                end
            end
            ST_PLL_LOCK: begin
                nxt_cnt = cnt_ff + 14'd1;
                if (cnt_ff == PLL_LAST) begin
                    nxt_state = ST_RESUME;
                    nxt_cnt   = '0;
                    nxt_lim   = (keep_ff[KEEP_MEM_LSB +: 2] <= MEM_FLASH_SLEEP)
                              ? RESUME_SLOW_CYC - 14'd1 : RESUME_RAM_CYC - 14'd1;
                end
            end
            ST_RESUME: begin
                nxt_cnt = cnt_ff + 14'd1;
                if (cnt_ff == lim_ff) begin
                    nxt_state  = ST_RUN;
                    nxt_resume = 1'b1;
                    nxt_irq    = keep_ff[KEEP_IEN_BIT];
                end
            end
        endcase

        // Enables follow the next state so each output is a plain flop
        nxt_clk_en[0] = nxt_state inside {ST_RUN, ST_FLUSH, ST_RESUME};
        nxt_clk_en[1] = nxt_state inside {ST_RUN, ST_FLUSH, ST_RESUME};
        nxt_clk_en[2] = nxt_state inside {ST_RUN, ST_FLUSH, ST_RESUME};
        nxt_clk_en[3] = !(nxt_state inside {ST_HALT, ST_OSC_START});
        nxt_clk_en[4] = nxt_state != ST_HALT;
        nxt_clk_en[5] = nxt_state != ST_HALT || keep_ff[KEEP_OSC1_BIT] || !keep_xtal;
        nxt_clk_en[6] = nxt_state != ST_HALT || keep_ff[KEEP_OSC2_BIT] || !keep_xtal;
        nxt_clk_en[7] = !(nxt_state inside {ST_HALT, ST_OSC_START, ST_PLL_LOCK}) || keep_wd;
        // Clock out keeps toggling until 32 cycles after sleep, whatever the flush length
        nxt_clk_en[8] = (nxt_ent > XCLK_LOW_MIN) ? 1'b0 : !clk_en_ff[8];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff  <= ST_RUN;
            ent_ff    <= 7'd0;
            qcnt_ff   <= 7'd0;
            cnt_ff    <= '0;
            lim_ff    <= '0;
            resume_ff <= 1'b0;
            irq_ff    <= 1'b0;
            clk_en_ff <= 9'h0ff;
        end else begin
            state_ff  <= nxt_state;
            ent_ff    <= nxt_ent;
            qcnt_ff   <= nxt_qcnt;
            cnt_ff    <= nxt_cnt;
            lim_ff    <= nxt_lim;
            resume_ff <= nxt_resume;
            irq_ff    <= nxt_irq;
            clk_en_ff <= nxt_clk_en;
        end
    end

    assign prdata                     = prdata_ff;
    assign pready                     = pready_ff;
    assign pslverr                    = pslverr_ff;
    assign system_clock_out_en        = clk_en_ff[0];
    assign core_clock_input_en        = clk_en_ff[1];
    assign peripheral_clock_en        = clk_en_ff[2];
    assign pll_en                     = clk_en_ff[3];
    assign oscillator_en              = clk_en_ff[4];
    assign internal_oscillator_one_en = clk_en_ff[5];
    assign internal_oscillator_two_en = clk_en_ff[6];
    assign watchdog_en                = clk_en_ff[7];
    assign external_clock_output      = clk_en_ff[8];
    assign program_resume             = resume_ff;
    assign wake_interrupt             = irq_ff;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence sleep_taken_s;
        (state_ff == ST_RUN) && sleep_exec;
    endsequence
    sequence flush_done_s;
        (state_ff == ST_FLUSH) && (nxt_state != ST_FLUSH);
    endsequence

    flush_length_a: assert property (flush_done_s |-> ent_ff == flush_cyc)
        else $error("flush delay length wrong");
    flush_clock_a: assert property (flush_done_s |-> system_clock_out_en ##1 !system_clock_out_en)
        else $error("system clock not stopped after flush");
    standby_gate_a: assert property ((state_ff == ST_STANDBY)
        |-> !peripheral_clock_en && pll_en && watchdog_en && !core_clock_input_en)
        else $error("standby clock gating wrong");
    xclk_low_a: assert property (sleep_taken_s |-> ##45 !external_clock_output)
        else $error("external clock not low 45 cycles after sleep");
    xclk_early_a: assert property (sleep_taken_s |-> ##32 $changed(external_clock_output))
        else $error("external clock stopped too early");
    resume_bound_a: assert property ((state_ff == ST_RESUME)
        |-> cnt_ff < RESUME_SLOW_CYC && cnt_ff <= lim_ff)
        else $error("resume latency exceeded");
    halt_off_a: assert property ((state_ff == ST_HALT)
        |-> !oscillator_en && !core_clock_input_en && !pll_en && !peripheral_clock_en)
        else $error("halt left a clock running");
    keepalive_wd_a: assert property ((state_ff == ST_HALT) |-> watchdog_en == keep_wd)
        else $error("watchdog keep-alive not honoured");
    halt_wake_a: assert property ((state_ff == ST_HALT) && wake_fall
        |=> (state_ff == ST_OSC_START) && oscillator_en)
        else $error("halt wake edge did not start oscillator");
    pll_wait_a: assert property ((state_ff == ST_PLL_LOCK)
        |-> !core_clock_input_en && pll_en && cnt_ff <= PLL_LAST)
        else $error("core clock enabled during PLL lock");
    irq_gate_a: assert property (wake_interrupt |-> program_resume && keep_ff[KEEP_IEN_BIT])
        else $error("wake interrupt without enable");
    mode_pick_a: assert property (flush_done_s
        |=> (state_ff == ST_HALT) == $past(lpcfg_ff[CFG_HALT_BIT]))
        else $error("wrong low-power mode chosen");
endmodule : low_power_mode_sequencer
